// *** rtl/byte_fifo.v ***
// Small byte FIFO with registered read data
`default_nettype none

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_push,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_pop,
  output reg  [WIDTH-1:0] o_data,
  output reg              o_valid,
  output reg              o_full
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_reg;
  reg  [AW-1:0]    rd_ptr_reg;
  reg  [AW:0]      count_reg;
  reg  [AW:0]      count_next;
  wire             push_ok;
  wire             pop_ok;

  // Overflowing pushes and empty pops are dropped here
  assign push_ok = i_push & ~o_full;
  assign pop_ok  = i_pop & o_valid;

  // Occupancy after this cycle
  always @*
  begin
    count_next = count_reg;
    if (push_ok && !pop_ok)
      count_next = count_reg + {{AW{1'b0}}, 1'b1};
    else if (pop_ok && !push_ok)
      count_next = count_reg - {{AW{1'b0}}, 1'b1};
  end

  // Storage has no reset; pointers, count, flags and read data do
  always @(posedge i_clk)
  begin
    if (push_ok)
      mem[wr_ptr_reg] <= i_data;
  end

  // Head word lags one cycle behind the pointers
  // Valid waits for the head word, so a taker never sees stale data
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      o_data     <= {WIDTH{1'b0}};
      o_valid    <= 1'b0;
      o_full     <= 1'b0;
    end
    else
    begin
      if (push_ok)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}}
                      : wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (pop_ok)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}}
                      : rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      count_reg <= count_next;
      o_data    <= mem[rd_ptr_reg];
      o_valid   <= (count_reg != {(AW+1){1'b0}}) & ~pop_ok;
      o_full    <= (count_next == DEPTH);
    end
  end

endmodule

`default_nettype wire

// *** rtl/error_flag.v ***
// Sticky error flag, hardware set beats read clear
`default_nettype none

module error_flag (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_enable,
  input  wire i_set,
  input  wire i_clear,
  output reg  o_flag
);

  // Frozen while the channel is disabled, not while idle-stopped
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_flag <= 1'b0;
    else if (i_enable)
    begin
      if (i_set)
        o_flag <= 1'b1;
      else if (i_clear)
        o_flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** rtl/serial_channel_defines.vh ***
// Constants for the serial channel register front end
//
// What this block does
// - Channel idle until enable bit 0 set
// - Disabled channel freezes all other registers but the TX FIFO config
// - Disable keeps settings except TX trigger level
// - TX FIFO config reset when disabled or idle-stopped
// - Buffer write queues TX, read returns RX
// - Bit 7 shows received ninth bit, 9-bit mode
// - Bit 6 parity sense: 0 odd, 1 even
// - Bit 5 enables parity add and check
// - Parity only in 7-bit and 8-bit UART
// - Bit 4 overrun flag set on RX overrun
// - Bit 3 flags parity error or under-run
// - Bit 2 flags invalid stop bit
// - Reading control register clears the error flags
// - Edge select 0: out falling, in rising, idle high
// - Edge select 1: out rising, in falling, idle low
// - Clock select 0 baud generator, 1 pin
// - Mode field: sync, 7, 8, 9-bit UART
// - Idle-run bit: 0 stops, 1 runs in idle
`ifndef SERIAL_CHANNEL_DEFINES_VH
`define SERIAL_CHANNEL_DEFINES_VH

// Byte addresses of the registers
`define OFS_ENABLE      8'h00
`define OFS_BUFFER      8'h04
`define OFS_CONTROL     8'h08
`define OFS_MODE0       8'h0C
`define OFS_MODE1       8'h18
`define OFS_TX_FIFO_CFG 8'h24

// Enable register
`define EN_BIT          0

// Control register fields
`define CR_NINTH_BIT    7
`define CR_EVEN_BIT     6
`define CR_PAR_EN_BIT   5
`define CR_OVR_BIT      4
`define CR_PAR_UR_BIT   3
`define CR_FRM_BIT      2
`define CR_EDGE_BIT     1
`define CR_SRC_BIT      0
`define CR_RW_MASK      8'h63

// Mode register 0 transfer mode field and mode codes
`define MODE_HI         3
`define MODE_LO         2
`define MODE_SYNC       2'h0
`define MODE_UART7      2'h1
`define MODE_UART8      2'h2
`define MODE_UART9      2'h3

// Mode register 1 idle-run bit
`define IDLE_RUN_BIT    7

// TX FIFO configuration: trigger level field
`define TFC_TIL_HI      1
`define TFC_TIL_LO      0

// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000
`define RST_TFC         8'h00

`endif

// *** rtl/serial_channel_regs.v ***
// APB register front end of one serial channel
//
// The APB slave port and the register offsets were left to the implementer.
`include "serial_channel_defines.vh"
`default_nettype none

module serial_channel_regs #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_idle_mode,
  input  wire        i_tx_take,
  output wire [7:0]  o_tx_data,
  output wire        o_tx_valid,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  input  wire        i_rx_ninth,
  input  wire        i_parity_err,
  input  wire        i_underrun,
  input  wire        i_framing_err,
  output reg         o_channel_active,
  output reg  [1:0]  o_mode,
  output reg         o_parity_enable,
  output reg         o_parity_even,
  output reg         o_shift_on_rise,
  output reg         o_sclk_idle_high,
  output reg         o_clk_from_pin,
  output reg  [1:0]  o_tx_trigger_level
);

  reg        enable_reg;
  reg  [7:0] control_reg;
  reg  [7:0] mode0_reg;
  reg  [7:0] mode1_reg;
  reg  [7:0] tfc_reg;
  reg        ninth_reg;
  reg  [31:0] rdata_next;
  reg        slverr_next;
  wire       access;
  wire       done;
  wire       wr_done;
  wire       rd_done;
  wire       sel_enable;
  wire       sel_buffer;
  wire       sel_control;
  wire       sel_mode0;
  wire       sel_mode1;
  wire       sel_tfc;
  wire       mapped;
  wire       active;
  wire       tfc_reinit;
  wire       nine_bit;
  wire       rx_full;
  wire       rx_valid;
  wire [7:0] rx_head;
  wire [2:0] flag_set;
  wire [2:0] flag_q;
  wire       flag_clear;

  // Access phase waits one cycle so FIFO head data has settled
  assign access  = i_psel & i_penable;
  assign done    = access & o_pready;
  assign wr_done = done & i_pwrite & mapped;
  assign rd_done = done & ~i_pwrite & mapped;

  // Address decode; low address bits must be zero
  assign sel_enable  = (i_paddr == `OFS_ENABLE);
  assign sel_buffer  = (i_paddr == `OFS_BUFFER);
  assign sel_control = (i_paddr == `OFS_CONTROL);
  assign sel_mode0   = (i_paddr == `OFS_MODE0);
  assign sel_mode1   = (i_paddr == `OFS_MODE1);
  assign sel_tfc     = (i_paddr == `OFS_TX_FIFO_CFG);
  assign mapped = sel_enable | sel_buffer | sel_control |
                  sel_mode0 | sel_mode1 | sel_tfc;

  // Gate stands in for the clock gate on the queues, error events, ninth bit and TX FIFO config
  assign active = enable_reg &
                  ~(i_idle_mode & ~mode1_reg[`IDLE_RUN_BIT]);
  assign tfc_reinit = ~active;
  assign nine_bit = (mode0_reg[`MODE_HI:`MODE_LO] == `MODE_UART9);

  // Enable bit is never gated so software can restart the channel
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      enable_reg <= 1'b0;
    else if (wr_done && sel_enable)
      enable_reg <= i_pwdata[`EN_BIT];
  end

  // Settings survive a disable because updates need enable_reg
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      control_reg <= `RST_BYTE;
      mode0_reg   <= `RST_BYTE;
      mode1_reg   <= `RST_BYTE;
      ninth_reg   <= 1'b0;
    end
    else if (enable_reg)
    begin
      if (wr_done && sel_control)
        control_reg <= i_pwdata[7:0] & `CR_RW_MASK;
      if (wr_done && sel_mode0)
        mode0_reg <= i_pwdata[7:0];
      if (wr_done && sel_mode1)
        mode1_reg <= i_pwdata[7:0];
      if (active && i_rx_valid && nine_bit)
        ninth_reg <= i_rx_ninth;
    end
  end

  // Trigger level is the one setting lost when the channel stops
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tfc_reg <= `RST_TFC;
    else if (tfc_reinit)
      tfc_reg <= `RST_TFC;
    else if (wr_done && sel_tfc)
      tfc_reg <= i_pwdata[7:0];
  end

  // Transmit queue: one byte per buffer write
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) tx_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_push  (active & wr_done & sel_buffer),
    .i_data  (i_pwdata[7:0]),
    .i_pop   (active & i_tx_take),
    .o_data  (o_tx_data),
    .o_valid (o_tx_valid),
    .o_full  ()
  );

  // Receive queue: one byte popped per buffer read
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) rx_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_push  (active & i_rx_valid),
    .i_data  (i_rx_data),
    .i_pop   (active & rd_done & sel_buffer),
    .o_data  (rx_head),
    .o_valid (rx_valid),
    .o_full  (rx_full)
  );

  // Error events; a byte arriving at a full queue is an overrun
  assign flag_set[0] = active & i_framing_err;
  assign flag_set[1] = active & (i_parity_err | i_underrun);
  assign flag_set[2] = active & i_rx_valid & rx_full;
  assign flag_clear  = rd_done & sel_control;

  // One sticky flag per error bit; only bits that went out on the bus
  // are cleared, so an error landing after the capture is not lost
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_flag
      error_flag flag_i (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_enable (enable_reg),
        .i_set    (flag_set[gi]),
        .i_clear  (flag_clear & o_prdata[`CR_FRM_BIT + gi]),
        .o_flag   (flag_q[gi])
      );
    end
  endgenerate

  // Read mux; upper bits read zero, unmapped reads zero with error
  always @*
  begin
    rdata_next  = `RST_WORD;
    slverr_next = ~mapped;
    if (sel_enable)
      rdata_next[`EN_BIT] = enable_reg;
    if (sel_buffer)
      rdata_next[7:0] = rx_valid ? rx_head : `RST_BYTE;
    if (sel_control)
    begin
      rdata_next[7:0] = control_reg;
      rdata_next[`CR_NINTH_BIT] = ninth_reg & nine_bit;
      rdata_next[`CR_OVR_BIT]   = flag_q[2];
      rdata_next[`CR_PAR_UR_BIT] = flag_q[1];
      rdata_next[`CR_FRM_BIT]   = flag_q[0];
    end
    if (sel_mode0)
      rdata_next[7:0] = mode0_reg;
    if (sel_mode1)
      rdata_next[7:0] = mode1_reg;
    if (sel_tfc)
      rdata_next[7:0] = tfc_reg;
  end

  // One wait state, then data and ready for exactly one cycle
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= `RST_WORD;
      o_pslverr <= 1'b0;
    end
    else if (access && !o_pready)
    begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? `RST_WORD : rdata_next;
      o_pslverr <= slverr_next;
    end
    else
    begin
      o_pready  <= 1'b0;
      o_prdata  <= `RST_WORD;
      o_pslverr <= 1'b0;
    end
  end

  // Settings toward the shifters, registered for clean outputs
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_channel_active   <= 1'b0;
      o_mode             <= `MODE_SYNC;
      o_parity_enable    <= 1'b0;
      o_parity_even      <= 1'b0;
      o_shift_on_rise    <= 1'b0;
      o_sclk_idle_high   <= 1'b1;
      o_clk_from_pin     <= 1'b0;
      o_tx_trigger_level <= 2'h0;
    end
    else
    begin
      o_channel_active <= active;
      o_mode <= mode0_reg[`MODE_HI:`MODE_LO];
      // Parity never reaches the frame in sync or 9-bit modes
      o_parity_enable <= control_reg[`CR_PAR_EN_BIT] &
                         (mode0_reg[`MODE_HI:`MODE_LO] == `MODE_UART7 |
                          mode0_reg[`MODE_HI:`MODE_LO] == `MODE_UART8);
      o_parity_even   <= control_reg[`CR_EVEN_BIT];
      // Edge select 1: shift on rise, sample on fall, idle low
      o_shift_on_rise  <= control_reg[`CR_EDGE_BIT];
      o_sclk_idle_high <= ~control_reg[`CR_EDGE_BIT];
      o_clk_from_pin   <= control_reg[`CR_SRC_BIT];
      o_tx_trigger_level <= tfc_reg[`TFC_TIL_HI:`TFC_TIL_LO];
    end
  end

endmodule

`default_nettype wire

// *** testbench/serial_channel_sva.sv ***
// Port-level checker for the serial channel register front end
`default_nettype none
module serial_channel_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_tx_valid,
  input wire logic        o_channel_active,
  input wire logic [1:0]  o_mode,
  input wire logic        o_parity_enable,
  input wire logic        o_shift_on_rise,
  input wire logic        o_sclk_idle_high,
  input wire logic [1:0]  o_tx_trigger_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Exactly one wait state, then a single ready pulse
  a_ready_wait: assert property (i_psel && i_penable && !o_pready
    |=> o_pready) else $error("ready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held");
  a_err_ready: assert property (o_pslverr |-> o_pready && !o_prdata)
    else $error("error without ready");
  a_upper_zero: assert property (o_prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_idle_level: assert property (o_sclk_idle_high != o_shift_on_rise)
    else $error("idle level wrong");
  a_parity_modes: assert property (o_parity_enable
    |-> o_mode == 2'h1 || o_mode == 2'h2) else $error("parity mode");
  // Two idle cycles allow for the register lag of the trigger field
  a_trig_cleared: assert property (!o_channel_active [*2]
    |=> o_tx_trigger_level == 2'h0) else $error("trigger kept");
  a_frozen_tx: assert property (!o_channel_active [*2]
    |-> $stable(o_tx_valid)) else $error("queue moved");
  c_err: cover property (o_pslverr);
  c_parity: cover property (o_parity_enable);
  c_wake: cover property (!o_channel_active ##1 o_channel_active);
endmodule
bind serial_channel_regs serial_channel_sva u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_tx_valid(o_tx_valid),
  .o_channel_active(o_channel_active), .o_mode(o_mode),
  .o_parity_enable(o_parity_enable),
  .o_shift_on_rise(o_shift_on_rise),
  .o_sclk_idle_high(o_sclk_idle_high),
  .o_tx_trigger_level(o_tx_trigger_level));
`default_nettype wire

// *** testbench/shift_peer.sv ***
// Behavioural shifter-side peer: takes TX bytes, delivers RX events
`default_nettype none
module shift_peer (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output var  logic       o_tx_take,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_data,
  output var  logic       o_rx_ninth,
  output var  logic [2:0] o_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       taking;
  logic [1:0] cnt;
  logic [7:0] got_q[$];
  initial
  begin
    taking = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'hFF;
    o_rx_ninth = 1'b0;
    o_err = 3'h0;
  end
  // Slow sink: one take every fourth cycle; taking low is a stall
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= 2'h0;
      o_tx_take <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      o_tx_take <= taking && i_tx_valid && cnt == 2'h0;
      if (o_tx_take)
        got_q.push_back(i_tx_data);
    end
  end
  // One unit; data and ninth-bit lines show the inverse afterwards, valid and errors go low, so stale data is caught
  task automatic send(input logic [7:0] d, input logic n,
                      input logic [2:0] e, input logic v);
    o_rx_valid <= v;
    o_rx_data <= d;
    o_rx_ninth <= n;
    o_err <= e;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~d;
    o_rx_ninth <= ~n;
    o_err <= 3'h0;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/test_serial_channel_enable_buffer_control.sv ***
// Self-checking bench for the serial channel register front end
`include "serial_channel_defines.vh"
`default_nettype none
module test_serial_channel_enable_buffer_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        idle = 1'b0;
  logic [31:0] prdata, rdat;
  logic [7:0]  tx_data, rx_data;
  logic [2:0]  err;
  logic [1:0]  mode, trig;
  logic        pready, pslverr, serr, tx_take, tx_valid, rx_valid;
  logic        rx_ninth, active, pe, even, rise, idle_hi, pin;
  int          num_errors = 0;
  int          n_tests = 0;
  serial_channel_regs dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_idle_mode(idle), .i_tx_take(tx_take),
    .o_tx_data(tx_data), .o_tx_valid(tx_valid),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_ninth(rx_ninth), .i_parity_err(err[2]),
    .i_underrun(err[1]), .i_framing_err(err[0]),
    .o_channel_active(active), .o_mode(mode),
    .o_parity_enable(pe), .o_parity_even(even),
    .o_shift_on_rise(rise), .o_sclk_idle_high(idle_hi),
    .o_clk_from_pin(pin), .o_tx_trigger_level(trig));
  shift_peer peer (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_tx_take(tx_take),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_ninth(rx_ninth), .o_err(err));
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1)
      @(posedge i_clk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic t_reset;
    rc(`OFS_ENABLE, 32'h0);
    rc(`OFS_BUFFER, 32'h0);
    rc(`OFS_CONTROL, 32'h0);
    chk(idle_hi, 1'b1);
  endtask
  task automatic t_disabled;
    wr(`OFS_CONTROL, 32'h63);
    rc(`OFS_CONTROL, 32'h0);
    wr(`OFS_BUFFER, 32'h11);
    cyc(4);
    chk({active, tx_valid}, 2'h0);
    wr(`OFS_ENABLE, 32'hFFFFFFFF);
    rc(`OFS_ENABLE, 32'h1);
    chk(active, 1'b1);
  endtask
  task automatic t_ctrl;
    wr(`OFS_CONTROL, 32'hFFFFFFFF);
    rc(`OFS_CONTROL, 32'h63);
    chk({even, rise, idle_hi, pin}, 4'hD);
    for (int m = 0; m < 4; m++)
    begin
      wr(`OFS_MODE0, m << 2);
      cyc(2);
      chk({mode, pe}, {m[1:0], m == 1 || m == 2});
    end
    wr(`OFS_MODE0, 32'h08);
    wr(`OFS_CONTROL, 32'h0);
    cyc(2);
    chk({even, rise, idle_hi, pin, pe}, 5'h04);
  endtask
  // Far side stalls while the queue fills and refuses the fifth byte
  task automatic t_buffer;
    wr(`OFS_BUFFER, 32'h123456A1);
    for (int i = 2; i < 6; i++)
      wr(`OFS_BUFFER, 32'hA0 + i);
    cyc(2);
    chk({tx_valid, tx_data}, 9'h1A1);
    peer.taking <= 1'b1;
    cyc(40);
    chk(peer.got_q.size(), 4);
    for (int i = 0; i < 4; i++)
      chk(peer.got_q[i], 8'hA1 + i);
    chk(tx_valid, 1'b0);
    peer.send(8'h3C, 1'b0, 3'h0, 1'b1);
    peer.send(8'hC3, 1'b0, 3'h0, 1'b1);
    rc(`OFS_BUFFER, 32'h3C);
    rc(`OFS_BUFFER, 32'hC3);
    rc(`OFS_BUFFER, 32'h0);
    rc(8'h40, 32'h0);
    chk(serr, 1'b1);
  endtask
  task automatic t_flags;
    wr(`OFS_MODE0, 32'h0C);
    peer.send(8'h5A, 1'b1, 3'h0, 1'b1);
    rc(`OFS_CONTROL, 32'h80);
    rc(`OFS_BUFFER, 32'h5A);
    for (int i = 0; i < 5; i++)
      peer.send(i[7:0], 1'b0, 3'h0, 1'b1);
    rc(`OFS_CONTROL, 32'h10);
    rc(`OFS_CONTROL, 32'h0);
    for (int i = 0; i < 4; i++)
      rc(`OFS_BUFFER, i);
    for (int i = 0; i < 3; i++)
    begin
      peer.send(8'h0, 1'b0, 3'h4 >> i, 1'b0);
      rc(`OFS_CONTROL, i < 2 ? 32'h08 : 32'h04);
    end
  endtask
  task automatic t_keep;
    wr(`OFS_MODE0, 32'h08);
    wr(`OFS_TX_FIFO_CFG, 32'h03);
    wr(`OFS_CONTROL, 32'h41);
    cyc(2);
    chk(trig, 2'h3);
    wr(`OFS_ENABLE, 32'h0);
    cyc(3);
    chk({active, trig}, 3'h0);
    rc(`OFS_CONTROL, 32'h41);
    rc(`OFS_MODE0, 32'h08);
    rc(`OFS_TX_FIFO_CFG, 32'h0);
    wr(`OFS_ENABLE, 32'h1);
    wr(`OFS_TX_FIFO_CFG, 32'h02);
    idle <= 1'b1;
    cyc(3);
    chk({active, trig}, 3'h0);
    wr(`OFS_MODE1, 32'h80);
    wr(`OFS_TX_FIFO_CFG, 32'h02);
    cyc(3);
    chk({active, trig}, 3'h6);
    idle <= 1'b0;
  endtask
  task automatic finish_test;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_disabled();
    t_ctrl();
    t_buffer();
    t_flags();
    t_keep();
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
